// ===== core/tcb_config_bank.sv
// Byte-indexed configuration store of a pressure transmitter, with decoded settings.
// Assumes the command layer hands over one decoded access per request pulse and the initialise command as a pulse.
// What this block does
// - Filter bit 0 toggles adaptive pressure filter, bit 1 temperature low-pass.
// - Oversampling ratio is two to the power eight plus filter bits 2-4.
// - Filter bits 5-6 select averaging over 1, 2, 4 or 8 samples.
// - Analogue entry bit 0 selects current output, bit 1 voltage output.
// - Analogue output follows pressure one when bit 4 set, else calculated channel.
// - Older firmware: analogue entry write changes bit 4 only.
// - Serial bits 0-3 are baud code: 0 is 9600, 1 is 115200.
// - Serial bit 4 enables parity; bit 5 picks odd (0) or even (1).
// - Serial bit 6 picks one or two stop bits.
// - Newer variant: serial entry write restarts device into uninitialised state.
// - Address entry holds bus address; only 1 to 255 stored.
// - Sensor type entry reports pressure one low nibble, pressure two high nibble.
// - Sample rate entry accepts only codes 5, 6, 7 for 120/240/480 SAMPLE_RATE_CODE.
// - Entry 20 is write-only; value 0x99 switches interface to PROTOCOL_SWITCH_COMMAND.
// - Conductivity span codes 1 to 4 pick ranges 0.2 to 200 mS.
// - Compensation codes 1, 2, 3 pick linear 25, linear 20, table 25.
// - Factory filter default entry is read-only, returns manufacture setting.
// - Measurement status entry is read-only mirror of the status byte.
// - Write to a non-writable entry answers exception 2.
// - Read of a missing or write-only entry answers exception 2.
// - Any access before initialisation answers exception 32.
`timescale 1ns/1ps
`default_nettype none

module tcb_config_bank
	import tcb_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Firmware variant and initialise command
	input  wire logic       fw_legacy,
	input  wire logic       init_pulse,
	// Access port
	input  wire logic       req_valid,
	input  wire tcb_req_t   req,
	output var  logic       rsp_valid,
	output var  tcb_rsp_t   rsp,
	// Read-only sources
	input  wire logic [7:0] factory_filter_in,
	input  wire logic [7:0] meas_status_in,
	input  wire logic [7:0] sensor_type_in,
	input  wire logic [7:0] switch_supported_in,
	// Status and events
	output var  logic       initialised,
	output var  logic       restart_pulse,
	output var  logic       sdi12_switch_pulse,
	// Filter settings
	output var  logic       adaptive_filter_en,
	output var  logic       temp_lowpass_en,
	output var  logic [15:0] oversampling_ratio,
	output var  tcb_avg_t   averaging_depth,
	output var  logic [3:0] averaging_samples,
	// Analogue output
	output var  logic       current_out_en,
	output var  logic       voltage_out_en,
	output var  logic       aout_follows_pressure_one,
	// Serial line
	output var  logic [3:0] baud_code,
	output var  logic [16:0] baud_rate,
	output var  logic       parity_en,
	output var  logic       parity_even,
	output var  logic       two_stop_bits,
	output var  logic [7:0] bus_node_address,
	// Sampling, conductivity and sensor types
	output var  logic [8:0] samples_per_second,
	output var  logic       conductivity_power,
	output var  logic [3:0] conductivity_span_sel,
	output var  logic [2:0] conductivity_tc_sel,
	output var  logic [3:0] pressure_one_type,
	output var  logic [3:0] pressure_two_type
);

	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic [15:0] pow2(input logic [3:0] e);
		pow2 = 16'h0001 << e;
	endfunction : pow2

	logic [7:0] filter_settings_reg;
	logic [7:0] analog_output_config_reg;
	logic [7:0] serial_line_settings_reg;
	logic [7:0] bus_node_address_reg;
	logic [7:0] sample_rate_code_reg;
	logic [7:0] conductivity_power_reg;
	logic [7:0] conductivity_span_reg;
	logic [7:0] conductivity_tc_method_reg;
	logic       init_reg;

	// Entry classification.
	wire logic [7:0] idx = req.index;
	wire logic [7:0] wd  = req.wdata;
	wire logic hit_flt  = (idx == IDX_FILTER_SETTINGS);
	wire logic hit_aout = (idx == IDX_ANALOG_OUTPUT_CONFIG);
	wire logic hit_ser  = (idx == IDX_SERIAL_LINE_SETTINGS);
	wire logic hit_addr = (idx == IDX_BUS_NODE_ADDRESS);
	wire logic hit_sps  = (idx == IDX_SAMPLE_RATE_CODE);
	wire logic hit_sw   = (idx == IDX_PROTOCOL_SWITCH_CMD);
	wire logic hit_cpw  = (idx == IDX_CONDUCTIVITY_POWER);
	wire logic hit_crg  = (idx == IDX_CONDUCTIVITY_SPAN);
	wire logic hit_ctc  = (idx == IDX_CONDUCTIVITY_TC_METHOD);
	wire logic hit_ro   = (idx == IDX_FACTORY_FILTER_DEFAULT) || (idx == IDX_MEASUREMENT_STATUS) ||
	                      (idx == IDX_SENSOR_CALIBRATION) || (idx == IDX_PROTOCOL_SWITCH_SUPP);

	wire logic readable = hit_flt | hit_aout | hit_ser | hit_addr | hit_sps | hit_cpw | hit_crg | hit_ctc | hit_ro;

	// Value checks; a value the entry cannot hold is treated as a refused write.
	wire logic addr_ok = (wd >= ADDR_MIN);
	wire logic sps_ok  = in_range(wd, SPS_CODE_MIN, SPS_CODE_MAX);
	wire logic crg_ok  = in_range(wd, SPAN_CODE_MIN, SPAN_CODE_MAX);
	wire logic ctc_ok  = in_range(wd, TC_CODE_MIN, TC_CODE_MAX);
	wire logic sw_ok   = (wd == SWITCH_TO_SDI12_CODE);

	wire logic writable = hit_flt | hit_aout | hit_ser | hit_cpw |
	                      (hit_addr & addr_ok) | (hit_sps & sps_ok) |
	                      (hit_crg & crg_ok) | (hit_ctc & ctc_ok) | (hit_sw & sw_ok);

	wire logic access_ok = req_valid & init_reg;
	wire logic wr_go     = access_ok & req.write & writable;

	wire logic [7:0] exc_next = !init_reg ? EXC_NOT_INIT :
	                            req.write ? (writable ? EXC_NONE : EXC_NOT_ALLOWED) :
	                            (readable ? EXC_NONE : EXC_NOT_ALLOWED);

	// Read multiplexer; the switch command entry reads nothing because it is not readable.
	logic [7:0] rdata_next;
	always_comb begin
		rdata_next = 8'h00;
		unique case (1'b1)
			hit_flt:  rdata_next = filter_settings_reg;
			hit_aout: rdata_next = analog_output_config_reg;
			hit_ser:  rdata_next = serial_line_settings_reg;
			hit_addr: rdata_next = bus_node_address_reg;
			hit_sps:  rdata_next = sample_rate_code_reg;
			hit_cpw:  rdata_next = conductivity_power_reg;
			hit_crg:  rdata_next = conductivity_span_reg;
			hit_ctc:  rdata_next = conductivity_tc_method_reg;
			(idx == IDX_FACTORY_FILTER_DEFAULT): rdata_next = factory_filter_in;
			(idx == IDX_MEASUREMENT_STATUS):     rdata_next = meas_status_in;
			(idx == IDX_SENSOR_CALIBRATION):     rdata_next = sensor_type_in;
			(idx == IDX_PROTOCOL_SWITCH_SUPP):   rdata_next = switch_supported_in;
			default:  rdata_next = 8'h00;
		endcase
	end

	// Older firmware lets only the source select bit through.
	wire logic [7:0] aout_keep_mask = 8'h01 << AOUT_SOURCE_BIT;
	wire logic [7:0] aout_next = fw_legacy ?
	                             ((analog_output_config_reg & ~aout_keep_mask) | (wd & aout_keep_mask)) : wd;

	// A serial write on the newer variant restarts; the stored setting survives so it applies after restart.
	// The restart wins over an initialise pulse in the same cycle, so the host must initialise again.
	wire logic restart_next = wr_go & hit_ser & ~fw_legacy;
	wire logic init_next    = restart_next ? 1'b0 : (init_pulse ? 1'b1 : init_reg);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_settings_reg        <= RST_FILTER_SETTINGS;
			analog_output_config_reg   <= RST_ANALOG_OUTPUT;
			serial_line_settings_reg   <= RST_SERIAL_LINE;
			bus_node_address_reg       <= RST_BUS_NODE_ADDRESS;
			sample_rate_code_reg       <= RST_SAMPLE_RATE;
			conductivity_power_reg     <= RST_COND_POWER;
			conductivity_span_reg      <= RST_COND_SPAN;
			conductivity_tc_method_reg <= RST_COND_TC;
		end else if (wr_go) begin
			if (hit_flt)  filter_settings_reg        <= wd;
			if (hit_aout) analog_output_config_reg   <= aout_next;
			if (hit_ser)  serial_line_settings_reg   <= wd;
			if (hit_addr) bus_node_address_reg       <= wd;
			if (hit_sps)  sample_rate_code_reg       <= wd;
			if (hit_cpw)  conductivity_power_reg     <= wd;
			if (hit_crg)  conductivity_span_reg      <= wd;
			if (hit_ctc)  conductivity_tc_method_reg <= wd;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			init_reg           <= 1'b0;
			rsp_valid          <= 1'b0;
			rsp                <= '0;
			restart_pulse      <= 1'b0;
			sdi12_switch_pulse <= 1'b0;
		end else begin
			init_reg           <= init_next;
			rsp_valid          <= req_valid;
			rsp.exc            <= req_valid ? exc_next : EXC_NONE;
			rsp.rdata          <= (access_ok & ~req.write & readable) ? rdata_next : 8'h00;
			restart_pulse      <= restart_next;
			sdi12_switch_pulse <= wr_go & hit_sw;
		end
	end

	// Decoded settings, registered one cycle after the stored entries.
	// A host that acts on a decoded setting must allow two cycles after the write request.
	// Registering every decode costs a cycle of latency but keeps all outputs glitch free.
	// Codes that the value checks refuse never reach these registers, so the offsets below
	// stay inside their tables; only the baud code may hold a value with no rate, shown as zero.
	wire logic [2:0] osr_field = filter_settings_reg[FLT_OSR_LSB +: 3];
	wire logic [1:0] avg_field = filter_settings_reg[FLT_AVG_LSB +: 2];
	wire logic [3:0] ser_baud  = serial_line_settings_reg[SER_BAUD_LSB +: 4];
	wire logic [2:0] sps_off   = 3'(sample_rate_code_reg - SPS_CODE_MIN);
	wire logic [1:0] crg_off   = 2'(conductivity_span_reg - SPAN_CODE_MIN);
	wire logic [1:0] ctc_off   = 2'(conductivity_tc_method_reg - TC_CODE_MIN);
	wire logic [16:0] baud_dec = (ser_baud == BAUD_CODE_115200) ? BAUD_115200 :
	                             (ser_baud == BAUD_CODE_9600) ? BAUD_9600 : 17'h00000;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			initialised               <= 1'b0;
			adaptive_filter_en        <= 1'b0;
			temp_lowpass_en           <= 1'b0;
			oversampling_ratio        <= 16'h0100;
			averaging_depth           <= TCB_AVG_1;
			averaging_samples         <= 4'h1;
			current_out_en            <= 1'b0;
			voltage_out_en            <= 1'b0;
			aout_follows_pressure_one <= 1'b0;
			baud_code                 <= 4'h0;
			baud_rate                 <= 17'h00000;
			parity_en                 <= 1'b0;
			parity_even               <= 1'b0;
			two_stop_bits             <= 1'b0;
			bus_node_address          <= 8'h00;
			samples_per_second        <= 9'h000;
			conductivity_power        <= 1'b0;
			conductivity_span_sel     <= 4'h0;
			conductivity_tc_sel       <= 3'h0;
			pressure_one_type         <= 4'h0;
			pressure_two_type         <= 4'h0;
		end else begin
			initialised               <= init_reg;
			adaptive_filter_en        <= filter_settings_reg[FLT_ADAPTIVE_BIT];
			temp_lowpass_en           <= filter_settings_reg[FLT_TEMP_LP_BIT];
			oversampling_ratio        <= pow2(OSR_BASE_EXP + {1'b0, osr_field});
			averaging_depth           <= tcb_avg_t'(avg_field);
			averaging_samples         <= 4'(pow2({2'b00, avg_field}));
			current_out_en            <= analog_output_config_reg[AOUT_CURRENT_BIT];
			voltage_out_en            <= analog_output_config_reg[AOUT_VOLTAGE_BIT];
			aout_follows_pressure_one <= analog_output_config_reg[AOUT_SOURCE_BIT];
			baud_code                 <= ser_baud;
			baud_rate                 <= baud_dec;
			parity_en                 <= serial_line_settings_reg[SER_PARITY_EN_BIT];
			parity_even               <= serial_line_settings_reg[SER_PARITY_EV_BIT];
			two_stop_bits             <= serial_line_settings_reg[SER_STOP2_BIT];
			bus_node_address          <= bus_node_address_reg;
			samples_per_second        <= 9'(9'd120 << sps_off);
			conductivity_power        <= conductivity_power_reg[0];
			conductivity_span_sel     <= 4'(pow2({2'b00, crg_off}));
			conductivity_tc_sel       <= 3'(pow2({2'b00, ctc_off}));
			pressure_one_type         <= sensor_type_in[3:0];
			pressure_two_type         <= sensor_type_in[7:4];
		end
	end

endmodule : tcb_config_bank

`default_nettype wire

// ===== pkg/tcb_pkg.sv
// Shared constants and carriers for the transmitter configuration byte bank.
// Assumes a single device clock and an external command decoder that feeds single byte accesses.
package tcb_pkg;

	// Entry numbers.
	localparam logic [7:0] IDX_FILTER_SETTINGS        = 8'h07;
	localparam logic [7:0] IDX_ANALOG_OUTPUT_CONFIG   = 8'h09;
	localparam logic [7:0] IDX_SERIAL_LINE_SETTINGS   = 8'h0a;
	localparam logic [7:0] IDX_FACTORY_FILTER_DEFAULT = 8'h0b;
	localparam logic [7:0] IDX_MEASUREMENT_STATUS     = 8'h0c;
	localparam logic [7:0] IDX_BUS_NODE_ADDRESS       = 8'h0d;
	localparam logic [7:0] IDX_SENSOR_CALIBRATION     = 8'h0e;
	localparam logic [7:0] IDX_SAMPLE_RATE_CODE       = 8'h0f;
	localparam logic [7:0] IDX_PROTOCOL_SWITCH_CMD    = 8'h14;
	localparam logic [7:0] IDX_CONDUCTIVITY_POWER     = 8'h1c;
	localparam logic [7:0] IDX_CONDUCTIVITY_SPAN      = 8'h1f;
	localparam logic [7:0] IDX_CONDUCTIVITY_TC_METHOD = 8'h20;
	localparam logic [7:0] IDX_PROTOCOL_SWITCH_SUPP   = 8'h21;

	// Field positions.
	localparam int FLT_ADAPTIVE_BIT  = 0;
	localparam int FLT_TEMP_LP_BIT   = 1;
	localparam int FLT_OSR_LSB       = 2;
	localparam int FLT_AVG_LSB       = 5;
	localparam int AOUT_CURRENT_BIT  = 0;
	localparam int AOUT_VOLTAGE_BIT  = 1;
	localparam int AOUT_SOURCE_BIT   = 4;
	localparam int SER_BAUD_LSB      = 0;
	localparam int SER_PARITY_EN_BIT = 4;
	localparam int SER_PARITY_EV_BIT = 5;
	localparam int SER_STOP2_BIT     = 6;
	localparam logic [3:0] OSR_BASE_EXP = 4'h8;

	// Codes and limits.
	localparam logic [7:0] SWITCH_TO_SDI12_CODE = 8'h99;
	localparam logic [7:0] ADDR_MIN             = 8'h01;
	localparam logic [7:0] SPS_CODE_MIN         = 8'h05;
	localparam logic [7:0] SPS_CODE_MAX         = 8'h07;
	localparam logic [7:0] SPAN_CODE_MIN        = 8'h01;
	localparam logic [7:0] SPAN_CODE_MAX        = 8'h04;
	localparam logic [7:0] TC_CODE_MIN          = 8'h01;
	localparam logic [7:0] TC_CODE_MAX          = 8'h03;
	localparam logic [3:0] BAUD_CODE_9600       = 4'h0;
	localparam logic [3:0] BAUD_CODE_115200     = 4'h1;
	localparam logic [16:0] BAUD_9600           = 17'h02580;
	localparam logic [16:0] BAUD_115200         = 17'h1c200;

	// Exception codes carried in the answer, zero meaning success.
	localparam logic [7:0] EXC_NONE       = 8'h00;
	localparam logic [7:0] EXC_NOT_ALLOWED = 8'h02;
	localparam logic [7:0] EXC_NOT_INIT   = 8'h20;

	// Reset values of the writable entries.
	localparam logic [7:0] RST_FILTER_SETTINGS  = 8'h00;
	localparam logic [7:0] RST_ANALOG_OUTPUT    = 8'h11;
	localparam logic [7:0] RST_SERIAL_LINE      = 8'h00;
	localparam logic [7:0] RST_BUS_NODE_ADDRESS = 8'h01;
	localparam logic [7:0] RST_SAMPLE_RATE      = 8'h05;
	localparam logic [7:0] RST_COND_POWER       = 8'h00;
	localparam logic [7:0] RST_COND_SPAN        = 8'h01;
	localparam logic [7:0] RST_COND_TC          = 8'h01;

	typedef struct packed {
		logic       write;
		logic [7:0] index;
		logic [7:0] wdata;
	} tcb_req_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic [7:0] exc;
	} tcb_rsp_t;

	typedef enum logic [1:0] {TCB_AVG_1, TCB_AVG_2, TCB_AVG_4, TCB_AVG_8} tcb_avg_t;

endpackage : tcb_pkg

// ===== tb/tcb_config_bank_asserts.sv
// Concurrent checks of the configuration bank's access port and decoded settings.
// Assumes it is bound into the bank and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tcb_config_bank_asserts
	import tcb_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Access port and controls
	input wire logic        fw_legacy,
	input wire logic        init_pulse,
	input wire logic        req_valid,
	input wire tcb_req_t    req,
	input wire logic        rsp_valid,
	input wire tcb_rsp_t    rsp,
	// Observed outputs
	input wire logic        initialised,
	input wire logic        restart_pulse,
	input wire logic        sdi12_switch_pulse,
	input wire logic        adaptive_filter_en,
	input wire logic [15:0] oversampling_ratio,
	input wire tcb_avg_t    averaging_depth,
	input wire logic [7:0]  bus_node_address
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// The internal state leads the initialised output by one cycle, hence the init_pulse exclusion.
	AST_NOT_INIT_REFUSED: assert property (req_valid && !initialised && !$past(init_pulse) |=> rsp.exc == 8'h20)
		else $error("access before initialisation not refused");
	AST_ANSWER_PULSE: assert property (req_valid |=> rsp_valid)
		else $error("no answer one cycle after request");
	AST_NO_SPURIOUS: assert property (!req_valid |=> !rsp_valid)
		else $error("answer without request");
	AST_SWITCH_READ: assert property (req_valid && !req.write && req.index == 8'h14 |=> rsp.exc != 8'h00 && rsp.rdata == 8'h00)
		else $error("write-only entry was readable");
	AST_ADDR_ZERO: assert property (req_valid && req.write && req.index == 8'h0d && req.wdata == 8'h00 |=> rsp.exc != 8'h00 ##1 $stable(bus_node_address))
		else $error("address zero was accepted");
	AST_SWITCH_PULSE: assert property (req_valid && req.write && req.index == 8'h14 && req.wdata == 8'h99 ##1 rsp.exc == 8'h00 |-> ##[0:1] sdi12_switch_pulse)
		else $error("no switch pulse after accepted switch code");
	AST_RESTART: assert property (req_valid && req.write && req.index == 8'h0a && !fw_legacy ##1 rsp.exc == 8'h00 |-> ##[0:1] restart_pulse)
		else $error("no restart after serial write");
	AST_FILTER_DECODE: assert property (req_valid && req.write && req.index == 8'h07 ##1 rsp.exc == 8'h00 |=>
		adaptive_filter_en == $past(req.wdata[0], 2) && oversampling_ratio == (16'h0100 << $past(req.wdata[4:2], 2))
		&& averaging_depth == tcb_avg_t'($past(req.wdata[6:5], 2))) else $error("filter settings decoded wrongly");
	COV_REFUSED_WRITE: cover property (req_valid && req.write ##1 rsp.exc == 8'h02);
	COV_RESTART: cover property (restart_pulse);
	COV_SWITCH: cover property (sdi12_switch_pulse);
endmodule : tcb_config_bank_asserts
bind tcb_config_bank tcb_config_bank_asserts u_chk (.ref_clk, .rst_n, .fw_legacy, .init_pulse, .req_valid, .req,
	.rsp_valid, .rsp, .initialised, .restart_pulse, .sdi12_switch_pulse, .adaptive_filter_en, .oversampling_ratio,
	.averaging_depth, .bus_node_address);
`default_nettype wire

// ===== tb/tcb_host_model.sv
// Host-side model of the command layer issuing single-byte configuration accesses.
// Assumes the bank answers exactly one cycle after each request; drives on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tcb_host_model
	import tcb_pkg::*;
(
	// Clock
	input  wire logic     ref_clk,
	// Access port
	output var  logic     req_valid,
	output var  tcb_req_t req,
	output var  logic     init_pulse,
	input  wire logic     rsp_valid,
	input  wire tcb_rsp_t rsp
);
	initial begin
		req_valid = 1'b0;
		req = '0;
		init_pulse = 1'b0;
	end
	task automatic initialise();
		init_pulse = 1'b1;
		@(negedge ref_clk);
		init_pulse = 1'b0;
	endtask : initialise
	// Released request fields show inverted data, so a stale value is never taken for a live one.
	task automatic access(input logic w, input logic [7:0] idx, input logic [7:0] wd, output tcb_rsp_t r,
		output logic ok);
		req_valid = 1'b1;
		req = '{write: w, index: idx, wdata: wd};
		@(negedge ref_clk);
		req_valid = 1'b0;
		req = ~req;
		ok = (rsp_valid === 1'b1);
		r = rsp;
		@(negedge ref_clk);
	endtask : access
endmodule : tcb_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: scenario tasks drive the configuration bank through the host model.
// Assumes the bound checker watches the bank; level inputs are driven here on falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	import tcb_pkg::*;
	logic        ref_clk, rst_n, fw_legacy, req_valid, init_pulse, rsp_valid, initialised;
	logic        adaptive_filter_en, temp_lowpass_en, current_out_en, voltage_out_en, aout_follows_pressure_one;
	logic        parity_en, parity_even, two_stop_bits, conductivity_power;
	tcb_avg_t    averaging_depth;
	logic [7:0]  ff_in, ms_in, st_in, sw_in, bus_node_address;
	logic [15:0] oversampling_ratio;
	logic [3:0]  averaging_samples, conductivity_span_sel, pressure_one_type, pressure_two_type, baud_code;
	logic [16:0] baud_rate;
	logic [8:0]  samples_per_second;
	logic [2:0]  conductivity_tc_sel;
	tcb_req_t    req;
	tcb_rsp_t    rsp, r;
	int          n_mismatch = 0;
	int          n_checks = 0;
	tcb_config_bank i_dut (.ref_clk, .rst_n, .fw_legacy, .init_pulse, .req_valid, .req, .rsp_valid, .rsp,
		.factory_filter_in(ff_in), .meas_status_in(ms_in), .sensor_type_in(st_in), .switch_supported_in(sw_in),
		.initialised, .restart_pulse(), .sdi12_switch_pulse(), .adaptive_filter_en, .temp_lowpass_en,
		.oversampling_ratio, .averaging_depth, .averaging_samples, .current_out_en, .voltage_out_en,
		.aout_follows_pressure_one, .baud_code, .baud_rate, .parity_en, .parity_even, .two_stop_bits,
		.bus_node_address, .samples_per_second, .conductivity_power, .conductivity_span_sel,
		.conductivity_tc_sel, .pressure_one_type, .pressure_two_type);
	tcb_host_model i_host (.ref_clk, .req_valid, .req, .init_pulse, .rsp_valid, .rsp);
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : summarize
	// A missing answer ends the run, since every later expectation would be skewed.
	task automatic acc(input logic w, input logic [7:0] idx, wd, ex, rd, input string nm);
		logic ok;
		i_host.access(w, idx, wd, r, ok);
		if (!ok) begin
			n_mismatch++;
			summarize();
		end
		`CHK(nm, ex, r.exc)
		if (!w) `CHK(nm, rd, r.rdata)
	endtask : acc
	task automatic t_init();
		acc(0, 8'h0d, 8'h00, 8'h20, 8'h00, "pre-init read");
		i_host.initialise();
		acc(0, 8'h0d, 8'h00, 8'h00, 8'h01, "address after init");
		$display("test init done");
	endtask : t_init
	task automatic t_filter();
		acc(1, 8'h07, 8'h7d, 8'h00, 8'h00, "filter write");
		`CHK("adaptive", 1'b1, adaptive_filter_en)
		`CHK("temp lowpass", 1'b0, temp_lowpass_en)
		`CHK("osr", 16'h0001 << (8 + 7), oversampling_ratio)
		`CHK("averaging", 4'h8, averaging_samples)
		`CHK("avg depth", TCB_AVG_8, averaging_depth)
		acc(0, 8'h07, 8'h00, 8'h00, 8'h7d, "filter read");
		$display("test filter done");
	endtask : t_filter
	task automatic t_addr_ro();
		acc(1, 8'h0d, 8'h00, 8'h02, 8'h00, "address zero");
		acc(0, 8'h0d, 8'h00, 8'h00, 8'h01, "address kept");
		acc(1, 8'h0d, 8'hff, 8'h00, 8'h00, "address max");
		`CHK("address out", 8'hff, bus_node_address)
		acc(1, 8'h0b, 8'h55, 8'h02, 8'h00, "ro write");
		acc(0, 8'h0b, 8'h00, 8'h00, ff_in, "factory filter");
		acc(0, 8'h0c, 8'h00, 8'h00, ms_in, "status");
		acc(0, 8'h0e, 8'h00, 8'h00, st_in, "sensor type");
		`CHK("p1 type", st_in[3:0], pressure_one_type)
		`CHK("p2 type", st_in[7:4], pressure_two_type)
		acc(0, 8'h30, 8'h00, 8'h02, 8'h00, "undefined read");
		acc(1, 8'h08, 8'h01, 8'h02, 8'h00, "undefined write");
		$display("test address and read-only done");
	endtask : t_addr_ro
	task automatic t_codes();
		int sp = 5;
		int sn = 1;
		int tm = 1;
		for (int c = 0; c < 9; c++) begin
			acc(1, 8'h0f, 8'(c), (c >= 5 && c <= 7) ? 8'h00 : 8'h02, 8'h00, "rate code");
			acc(1, 8'h1f, 8'(c), (c >= 1 && c <= 4) ? 8'h00 : 8'h02, 8'h00, "span code");
			acc(1, 8'h20, 8'(c), (c >= 1 && c <= 3) ? 8'h00 : 8'h02, 8'h00, "tc code");
			if (c >= 5 && c <= 7) sp = c;
			if (c >= 1 && c <= 4) sn = c;
			if (c >= 1 && c <= 3) tm = c;
			`CHK("rate value", 9'd120 << (sp - 5), samples_per_second)
			`CHK("span select", 4'h1 << (sn - 1), conductivity_span_sel)
			`CHK("tc select", 3'h1 << (tm - 1), conductivity_tc_sel)
		end
		acc(0, 8'h14, 8'h00, 8'h02, 8'h00, "switch read");
		acc(1, 8'h14, 8'h98, 8'h02, 8'h00, "switch bad code");
		acc(1, 8'h14, 8'h99, 8'h00, 8'h00, "switch code");
		acc(1, 8'h1c, 8'h01, 8'h00, 8'h00, "power write");
		`CHK("power on", 1'b1, conductivity_power)
		acc(0, 8'h1c, 8'h00, 8'h00, 8'h01, "power read");
		acc(0, 8'h21, 8'h00, 8'h00, sw_in, "switch supported");
		$display("test codes done");
	endtask : t_codes
	task automatic t_aout_serial();
		fw_legacy = 1'b1;
		acc(1, 8'h09, 8'h02, 8'h00, 8'h00, "legacy analogue write");
		acc(0, 8'h09, 8'h00, 8'h00, 8'h01, "analogue only bit4");
		`CHK("current out", 1'b1, current_out_en)
		`CHK("voltage out", 1'b0, voltage_out_en)
		`CHK("output source", 1'b0, aout_follows_pressure_one)
		acc(1, 8'h0a, 8'h71, 8'h00, 8'h00, "legacy serial write");
		`CHK("baud fast", 17'd115200, baud_rate)
		`CHK("baud code", 4'h1, baud_code)
		`CHK("parity even", 2'b11, {parity_en, parity_even})
		`CHK("two stop", 1'b1, two_stop_bits)
		`CHK("no restart", 1'b1, initialised)
		fw_legacy = 1'b0;
		acc(1, 8'h0a, 8'h20, 8'h00, 8'h00, "new serial write");
		acc(0, 8'h0a, 8'h00, 8'h20, 8'h00, "after restart");
		`CHK("baud slow", 17'd9600, baud_rate)
		`CHK("parity off", 2'b01, {parity_en, parity_even})
		i_host.initialise();
		acc(0, 8'h0a, 8'h00, 8'h00, 8'h20, "serial after init");
		acc(1, 8'h09, 8'h12, 8'h00, 8'h00, "new analogue write");
		`CHK("voltage new", 1'b1, voltage_out_en)
		`CHK("source new", 1'b1, aout_follows_pressure_one)
		$display("test analogue and serial done");
	endtask : t_aout_serial
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		rst_n = 1'b0;
		fw_legacy = 1'b0;
		{ff_in, ms_in, st_in, sw_in} = 32'h3ca52101;
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		t_init();
		t_filter();
		t_addr_ro();
		t_codes();
		t_aout_serial();
		summarize();
	end
endmodule : testbench
`default_nettype wire
